//--- rtl/prio_pkg.sv
// Purpose: Shared constants, field layout and carrier types for the interrupt priority register bank.
// Assumes: APB with 32-bit data, one aligned word per 16-bit register.
// Notes: Field indices below are the source numbers used on every per-source port.
// Notes on behaviour
// RULE1: Every source has a 3-bit priority field where 111 means level 7, the highest, and other codes their own level.
// RULE2: A field value of 001 gives its source the lowest active level, level 1.
// RULE3: A field value of 000 disables its source so it never requests service whatever its flag says.
// RULE4: Bits that hold no field are unimplemented, read as zero and ignore writes.
// RULE5: After power-on reset every field holds 100, so each source starts at level 4.
// RULE6: The first register holds uart1 receive in 14-12, spi1 event in 10-8, spi1 error in 6-4 and timer3 in 2-0.
// RULE7: The second register holds dma channel 1 in 10-8, adc done in 6-4 and uart1 transmit in 2-0, bits 15-11 empty.
// RULE8: The third register holds change notify in 14-12, comparator 1 in 10-8, i2c1 master in 6-4, i2c1 slave in 2-0.
// RULE9: The fourth register holds only external interrupt 1 in bits 2-0, with bits 15-3 empty.
// RULE10: The fifth register holds timer4 in 14-12, compare 4 in 10-8, compare 3 in 6-4 and dma channel 2 in 2-0.
// RULE11: The sixth register holds uart2 transmit in 14-12, uart2 receive in 10-8, external 2 in 6-4, timer5 in 2-0.
// RULE12: The seventh register holds can event in 14-12, can receive in 10-8, spi2 event in 6-4 and spi2 error in 2-0.
// RULE13: Without a CAN module the two CAN fields have no effect because their requests stay off.
// RULE14: A read returns the last value written to each field and zeros in every empty position.
package prio_pkg;

    localparam int NUM_REGS = 7;
    localparam int NUM_FIELDS = 24;
    localparam int PRIO_WIDTH = 3;
    localparam int REG_WIDTH = 16;
    localparam int ADDR_WIDTH = 12;
    localparam int INDEX_WIDTH = 3;

    localparam logic [ADDR_WIDTH-1:0] OFFSET_UART1RX_SPI1_TIMER3 = 12'h000;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_DMA1_ADC_UART1TX = 12'h004;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_CHANGE_NOTIFY_COMPARATOR_I2C1 = 12'h008;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_EXTERNAL_INT1 = 12'h00c;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_TIMER4_COMPARE34_DMA2 = 12'h010;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_UART2_EXT2_TIMER5 = 12'h014;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_CAN_SPI2 = 12'h018;

    // Level 4 after reset.
    localparam logic [PRIO_WIDTH-1:0] PRIO_RESET = 3'h4;
    localparam logic [PRIO_WIDTH-1:0] PRIO_DISABLED = 3'h0;

    localparam int FIELD_UART1_RECEIVE = 0;
    localparam int FIELD_SPI1_EVENT = 1;
    localparam int FIELD_SPI1_ERROR = 2;
    localparam int FIELD_TIMER3 = 3;
    localparam int FIELD_DMA_CH1 = 4;
    localparam int FIELD_ADC_DONE = 5;
    localparam int FIELD_UART1_TRANSMIT = 6;
    localparam int FIELD_CHANGE_NOTIFY = 7;
    localparam int FIELD_COMPARATOR1 = 8;
    localparam int FIELD_I2C1_MASTER = 9;
    localparam int FIELD_I2C1_SLAVE = 10;
    localparam int FIELD_EXTERNAL_INT1 = 11;
    localparam int FIELD_TIMER4 = 12;
    localparam int FIELD_COMPARE4 = 13;
    localparam int FIELD_COMPARE3 = 14;
    localparam int FIELD_DMA_CH2 = 15;
    localparam int FIELD_UART2_TRANSMIT = 16;
    localparam int FIELD_UART2_RECEIVE = 17;
    localparam int FIELD_EXTERNAL_INT2 = 18;
    localparam int FIELD_TIMER5 = 19;
    localparam int FIELD_CAN_EVENT = 20;
    localparam int FIELD_CAN_RECEIVE = 21;
    localparam int FIELD_SPI2_EVENT = 22;
    localparam int FIELD_SPI2_ERROR = 23;

    // Register index (offset / 4) and lowest bit of each field, in field order.
    localparam int FIELD_REG [NUM_FIELDS] = '{
        0, 0, 0, 0,
        1, 1, 1,
        2, 2, 2, 2,
        3,
        4, 4, 4, 4,
        5, 5, 5, 5,
        6, 6, 6, 6
    };
    localparam int FIELD_LSB [NUM_FIELDS] = '{
        12, 8, 4, 0,
        8, 4, 0,
        12, 8, 4, 0,
        0,
        12, 8, 4, 0,
        12, 8, 4, 0,
        12, 8, 4, 0
    };

    typedef logic [PRIO_WIDTH-1:0] prio_t;
    typedef prio_t [NUM_FIELDS-1:0] prio_bank_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_WIDTH-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic wr_en;
        logic [INDEX_WIDTH-1:0] index;
        logic [REG_WIDTH-1:0] data;
        logic [1:0] strb;
    } field_write_t;

endpackage

//--- rtl/priority_store.sv
// Purpose: Holds every priority field and applies register writes to them.
// Assumes: One write per cycle at most, presented by the bus slave on the completing edge.
// Notes: Only field bits are stored, so empty positions cannot hold anything.
`timescale 1ns/1ns
module priority_store
    import prio_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire field_write_t wr,
    output prio_bank_t fields
);

    typedef struct packed {
        prio_bank_t fields;
    } store_state_t;

    store_state_t state_reg;
    store_state_t state_next;
    logic [NUM_FIELDS-1:0] hit;

    for (genvar g = 0; g < NUM_FIELDS; g++)
    begin : g_hit
        // A field changes only when its own register and its byte lane are written.
        assign hit[g] = wr.wr_en && (wr.index == INDEX_WIDTH'(FIELD_REG[g])) && wr.strb[FIELD_LSB[g] / 8]; // RULE4
    end

    always_comb
    begin
        state_next = state_reg;
        for (int i = 0; i < NUM_FIELDS; i++)
        begin
            if (hit[i])
            begin
                state_next.fields[i] = wr.data[FIELD_LSB[i] +: PRIO_WIDTH]; // RULE14
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= {NUM_FIELDS{PRIO_RESET}}; // RULE5
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign fields = state_reg.fields;

endmodule

//--- rtl/request_gate.sv
// Purpose: Turns source flags and priority fields into registered service requests and levels.
// Assumes: Flags come from logic on the same clock.
// Notes: Arbitration among requests happens elsewhere; this only qualifies each source.
`timescale 1ns/1ns
module request_gate
    import prio_pkg::*;
#(
    parameter bit CAN_PRESENT = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire prio_bank_t fields,
    input wire logic [NUM_FIELDS-1:0] flags,
    output logic [NUM_FIELDS-1:0] requests,
    output prio_bank_t levels
);

    typedef struct packed {
        logic [NUM_FIELDS-1:0] requests;
        prio_bank_t levels;
    } gate_state_t;

    gate_state_t state_reg;
    gate_state_t state_next;
    logic [NUM_FIELDS-1:0] present;

    for (genvar g = 0; g < NUM_FIELDS; g++)
    begin : g_present
        if (g == FIELD_CAN_EVENT || g == FIELD_CAN_RECEIVE)
        begin : g_can
            assign present[g] = CAN_PRESENT; // RULE13
        end
        else
        begin : g_other
            assign present[g] = 1'b1;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        for (int i = 0; i < NUM_FIELDS; i++)
        begin
            // Code 000 never requests; 001 to 111 request at that very level.
            state_next.requests[i] = flags[i] && present[i] && (fields[i] != PRIO_DISABLED); // RULE3
            state_next.levels[i] = state_next.requests[i] ? fields[i] : PRIO_DISABLED; // RULE1 RULE2
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign requests = state_reg.requests;
    assign levels = state_reg.levels;

endmodule

//--- rtl/interrupt_priority_regs.sv
// Purpose: APB slave for the seven interrupt priority registers, with per-source request qualification.
// Assumes: APB master keeps address and data stable through the access phase.
// Notes: Every transfer completes with one access cycle; unmapped offsets answer with an error.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module interrupt_priority_regs
    import prio_pkg::*;
#(
    parameter bit CAN_PRESENT = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_t apb_in,
    output apb_rsp_t apb_out,
    input wire logic [NUM_FIELDS-1:0] source_flags,
    output prio_bank_t priorities,
    output logic [NUM_FIELDS-1:0] source_requests,
    output prio_bank_t source_levels
);

    typedef struct packed {
        apb_rsp_t rsp;
    } slave_state_t;

    slave_state_t state_reg;
    slave_state_t state_next;
    field_write_t wr;
    logic setup;
    logic mapped;
    logic [INDEX_WIDTH-1:0] index;
    logic [REG_WIDTH-1:0] read_word;

    assign setup = apb_in.psel && !apb_in.penable;
    assign mapped = (apb_in.paddr[ADDR_WIDTH-1:2] < (ADDR_WIDTH-2)'(NUM_REGS)) && (apb_in.paddr[1:0] == 2'h0);
    assign index = apb_in.paddr[INDEX_WIDTH+1:2];

    // Empty bit positions stay zero because only field bits are placed.
    always_comb
    begin
        read_word = '0;
        for (int i = 0; i < NUM_FIELDS; i++)
        begin
            if (index == INDEX_WIDTH'(FIELD_REG[i]))
            begin
                read_word[FIELD_LSB[i] +: PRIO_WIDTH] = priorities[i]; // RULE4 RULE14 RULE6 RULE7 RULE8
            end
        end
    end

    // The write lands on the edge where pready is sampled high.
    always_comb
    begin
        wr.wr_en = apb_in.psel && apb_in.penable && apb_in.pwrite && state_reg.rsp.pready && !state_reg.rsp.pslverr;
        wr.index = index;
        wr.data = apb_in.pwdata[REG_WIDTH-1:0];
        wr.strb = apb_in.pstrb[1:0];
    end

    always_comb
    begin
        state_next = state_reg;
        state_next.rsp.pready = setup;
        state_next.rsp.pslverr = setup && !mapped;
        if (setup && !apb_in.pwrite && mapped)
        begin
            state_next.rsp.prdata = {16'h0000, read_word}; // RULE9 RULE10 RULE11 RULE12
        end
        else if (setup)
        begin
            state_next.rsp.prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign apb_out = state_reg.rsp;

    priority_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr),
        .fields(priorities)
    );

    request_gate #(
        .CAN_PRESENT(CAN_PRESENT)
    ) u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .fields(priorities),
        .flags(source_flags),
        .requests(source_requests),
        .levels(source_levels)
    );

endmodule

//--- test/interrupt_priority_regs_monitor.sv
// Purpose: Port checks for the interrupt priority register bank.
// Assumes: One clock pclk and the asynchronous reset presetn.
// Notes: Bound to every instance, so each CAN_PRESENT value is watched.
`timescale 1ns/1ns
module interrupt_priority_regs_monitor
    import prio_pkg::*;
#(
    parameter bit CAN_PRESENT = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_t apb_in,
    input wire apb_rsp_t apb_out,
    input wire logic [NUM_FIELDS-1:0] source_flags,
    input wire prio_bank_t priorities,
    input wire logic [NUM_FIELDS-1:0] source_requests,
    input wire prio_bank_t source_levels
);
    logic [NUM_FIELDS-1:0] live;
    wire setup = apb_in.psel & ~apb_in.penable;
    wire done = apb_in.psel & apb_in.penable & apb_out.pready;
    // A source may request only with a nonzero field, and CAN sources only when fitted.
    always_comb
    begin
        for (int i = 0; i < NUM_FIELDS; i++)
        begin
            live[i] = (|priorities[i]) & (CAN_PRESENT | ((i != FIELD_CAN_EVENT) && (i != FIELD_CAN_RECEIVE)));
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_after_setup; setup |=> apb_out.pready; endproperty
    property p_ready_pulse; apb_out.pready |=> !apb_out.pready; endproperty
    property p_empty_zero; apb_out.pready |-> (apb_out.prdata & 32'hffff8888) == 32'h0; endproperty
    property p_bad_addr;
        done && (apb_in.paddr[11:2] >= 10'd7 || apb_in.paddr[1:0] != 2'b00) |-> apb_out.pslverr;
    endproperty
    property p_reset_value; $rose(presetn) |-> priorities == {NUM_FIELDS{PRIO_RESET}}; endproperty
    property p_write_timer3;
        done && apb_in.pwrite && apb_in.paddr == OFFSET_UART1RX_SPI1_TIMER3 && apb_in.pstrb[0]
            |=> priorities[FIELD_TIMER3] == $past(apb_in.pwdata[2:0]);
    endproperty
    property p_requests; 1'b1 |=> source_requests == $past(source_flags & live); endproperty
    property p_level_timer3;
        1'b1 |=> source_levels[FIELD_TIMER3] ==
            ($past(source_flags[FIELD_TIMER3]) ? $past(priorities[FIELD_TIMER3]) : PRIO_DISABLED);
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready missing");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    a_empty_zero: assert property (p_empty_zero) else $error("empty bit set");
    a_bad_addr: assert property (p_bad_addr) else $error("bad address accepted");
    a_reset_value: assert property (p_reset_value) else $error("wrong reset field");
    a_write_timer3: assert property (p_write_timer3) else $error("timer3 field not written");
    a_requests: assert property (p_requests) else $error("request mismatch");
    a_level_timer3: assert property (p_level_timer3) else $error("level mismatch");
    c_error: cover property (done && apb_out.pslverr);
    c_write: cover property (done && apb_in.pwrite);
    c_request: cover property (|source_requests);
endmodule
bind interrupt_priority_regs interrupt_priority_regs_monitor #(.CAN_PRESENT(CAN_PRESENT))
    u_interrupt_priority_regs_monitor (.pclk(pclk), .presetn(presetn), .apb_in(apb_in), .apb_out(apb_out),
    .source_flags(source_flags), .priorities(priorities), .source_requests(source_requests),
    .source_levels(source_levels));

//--- test/interrupt_priority_regs_tb.sv
// Purpose: Register and request checks for the interrupt priority register bank.
// Assumes: APB slave answers after a bounded wait.
// Notes: A second instance without CAN shares the bus.
`timescale 1ns/1ns
module interrupt_priority_regs_tb
    import prio_pkg::*;
;
    logic pclk;
    logic presetn;
    apb_req_t req;
    apb_rsp_t rsp;
    logic [23:0] flags;
    logic [23:0] rq_a;
    logic [23:0] rq_b;
    prio_bank_t lv_a;
    prio_bank_t lv_b;
    prio_bank_t pr_a;
    int error_cnt;
    int samples_checked;
    int r;
    int p;
    logic [31:0] q;
    logic e;
    logic [15:0] msk [7] = '{16'h7777, 16'h0777, 16'h7777, 16'h0007, 16'h7777, 16'h7777, 16'h7777};
    logic [31:0] pats [3] = '{32'hffffffff, 32'h0, 32'hffff7531};
    interrupt_priority_regs u_interrupt_priority_regs (.pclk(pclk), .presetn(presetn), .apb_in(req),
        .apb_out(rsp), .source_flags(flags), .priorities(pr_a), .source_requests(rq_a), .source_levels(lv_a));
    interrupt_priority_regs #(.CAN_PRESENT(1'b0)) u_interrupt_priority_regs_nocan (.pclk(pclk),
        .presetn(presetn), .apb_in(req), .apb_out(), .source_flags(flags), .priorities(),
        .source_requests(rq_b), .source_levels(lv_b));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic close_out();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d, s};
        @(posedge pclk);
        req.penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (rsp.pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            error_cnt++;
            close_out();
        end
        else
        begin
            q = rsp.prdata;
            e = rsp.pslverr;
            req.psel <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask
    initial
    begin
        presetn = 1'b0;
        req = '0;
        flags = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (r = 0; r < 7; r++)
        begin
            xfer(12'(r * 4), 32'h0, 1'b0, 4'hf);
            check("reset word", q, {16'h0, msk[r] & 16'h4444});
        end
        for (p = 0; p < 3; p++)
        begin
            for (r = 0; r < 7; r++)
            begin
                xfer(12'(r * 4), pats[p], 1'b1, 4'hf);
                xfer(12'(r * 4), 32'h0, 1'b0, 4'hf);
                check("readback", q, {16'h0, pats[p][15:0] & msk[r]});
            end
        end
        xfer(12'h01c, 32'hffff, 1'b1, 4'hf);
        check("unmapped error", {31'h0, e}, 32'h1);
        xfer(12'h002, 32'h0, 1'b1, 4'hf);
        check("misaligned error", {31'h0, e}, 32'h1);
        xfer(12'h000, 32'h0, 1'b0, 4'hf);
        check("word kept", q, 32'h7531);
        xfer(12'h000, 32'h7010, 1'b1, 4'hf);
        flags <= '1;
        repeat (2) @(posedge pclk);
        check("requests", {8'h0, rq_a}, 32'hfffff5);
        check("requests no can", {8'h0, rq_b}, 32'hcffff5);
        check("levels", {20'h0, lv_a[0], lv_a[1], lv_a[2], lv_a[3]}, 32'he08);
        check("levels no can", {23'h0, lv_b[FIELD_CAN_EVENT], lv_b[FIELD_CAN_RECEIVE], lv_b[FIELD_SPI2_ERROR]}, 32'h1);
        flags <= '0;
        repeat (2) @(posedge pclk);
        check("requests idle", {8'h0, rq_a}, 32'h0);
        xfer(12'h000, 32'hffff, 1'b1, 4'h1);
        xfer(12'h000, 32'h0, 1'b0, 4'hf);
        check("byte strobe", q, 32'h7077);
        check("stored timer3", {29'h0, pr_a[FIELD_TIMER3]}, 32'h7);
        xfer(12'h000, 32'h0, 1'b1, 4'h2);
        xfer(12'h000, 32'h0, 1'b0, 4'hf);
        check("upper lane", q, 32'h0077);
        close_out();
    end
endmodule
